// File: hdl/step_attenuator_control.sv
`include "attn_cfg.svh"
`default_nettype none
module step_attenuator_control
	import attn_pkg::*;
#(
	parameter int POWERUP_CYCLES = `ATTN_POWERUP_CYCLES
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic latch_enable,
	input wire logic serial_parallel_select,
	input wire logic [5:0] parallel_ctrl_bits,
	input wire logic powerup_select_a,
	input wire logic powerup_select_b,
	output logic [5:0] atten_code,
	output logic powerup_done,
	output logic serial_data_out
);

	localparam int CW = $clog2(POWERUP_CYCLES + 1);

	// map the two select pins to a start code
	function automatic code_t pup_code(input logic sel_a, input logic sel_b);
		code_t c;
		c = `ATTN_CODE_PUP_00;
		case ({sel_b, sel_a})
			2'h1: c = `ATTN_CODE_PUP_A;
			2'h2: c = `ATTN_CODE_PUP_B;
			2'h3: c = `ATTN_CODE_PUP_AB;
			default: c = `ATTN_CODE_PUP_00;
		endcase
		return c;
	endfunction

	// ---------------- clk domain ----------------
	logic le_m, le_s, ps_m, ps_s, pa_m, pa_s, pb_m, pb_s;
	code_t pbits_m, pbits_s, word_m, word_s;
	logic link_allow, next_link_allow;
	phase_e phase, next_phase;
	logic [CW-1:0] boot_cnt, next_boot_cnt;
	code_t next_atten_code;
	logic next_powerup_done;

	// ---------------- serial clock domain ----------------
	logic allow_m, allow_s;
	code_t shreg, next_shreg;
	logic next_serial_data_out;

	// two-flop synchronisers for pins and for the shifted word
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			le_m <= 1'b0;
			le_s <= 1'b0;
			ps_m <= 1'b0;
			ps_s <= 1'b0;
			pa_m <= 1'b0;
			pa_s <= 1'b0;
			pb_m <= 1'b0;
			pb_s <= 1'b0;
			pbits_m <= `ATTN_CODE_ZERO;
			pbits_s <= `ATTN_CODE_ZERO;
			word_m <= `ATTN_CODE_ZERO;
			word_s <= `ATTN_CODE_ZERO;
		end
		else if (ce)
		begin
			le_m <= latch_enable;
			le_s <= le_m;
			ps_m <= serial_parallel_select;
			ps_s <= ps_m;
			pa_m <= powerup_select_a;
			pa_s <= pa_m;
			pb_m <= powerup_select_b;
			pb_s <= pb_m;
			pbits_m <= parallel_ctrl_bits;
			pbits_s <= pbits_m;
			word_m <= shreg; // word is still while the latch masks shifting
			word_s <= word_m;
		end
	end

	// next values of phase, boot counter, state and shift permission
	always_comb
	begin
		next_phase = phase;
		next_boot_cnt = boot_cnt;
		next_atten_code = atten_code;
		next_powerup_done = powerup_done;
		// [R1] [R6] serial path open
		next_link_allow = ps_s & ~le_s;
		case (phase)
			PH_BOOT:
			begin
				// [R13] power-up delay count
				if (boot_cnt == CW'(POWERUP_CYCLES - 1))
				begin
					next_phase = PH_RUN;
					next_powerup_done = 1'b1;
					// [R12] latch high start
					if (le_s)
						next_atten_code = pbits_s;
					// [R11] select pin start
					else
						next_atten_code = pup_code(pa_s, pb_s);
				end
				else
					next_boot_cnt = boot_cnt + CW'(1);
			end
			PH_RUN:
			begin
				// [R8] [R17] hold unless latched
				if (le_s)
				begin
					// [R4] [R14] serial word load
					if (ps_s)
						next_atten_code = word_s;
					// [R7] [R14] parallel word load
					else
						next_atten_code = pbits_s;
				end
			end
			default:
			begin
				next_phase = PH_BOOT;
				next_boot_cnt = '0;
			end
		endcase
	end

	// state registers of the clk domain
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			phase <= PH_BOOT;
			boot_cnt <= '0;
			atten_code <= `ATTN_CODE_ZERO;
			powerup_done <= 1'b0;
			link_allow <= 1'b0;
		end
		else if (ce)
		begin
			phase <= next_phase;
			boot_cnt <= next_boot_cnt;
			atten_code <= next_atten_code;
			powerup_done <= next_powerup_done;
			link_allow <= next_link_allow;
		end
	end

	// shift permission crosses as a level into the serial clock domain
	always_ff @(posedge serial_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			allow_m <= 1'b0;
			allow_s <= 1'b0;
		end
		else
		begin
			allow_m <= link_allow;
			allow_s <= allow_m;
		end
	end

	// next shift register and cascade output
	always_comb
	begin
		next_shreg = shreg;
		next_serial_data_out = serial_data_out;
		// [R3] [R5] masked shift
		if (allow_s)
		begin
			// [R16] first bit ends in bit5
			next_shreg = {shreg[4:0], serial_data_in};
			// [R15] six-edge cascade delay
			next_serial_data_out = shreg[5];
		end
	end

	// shift register flops on the serial clock
	always_ff @(posedge serial_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			shreg <= `ATTN_CODE_ZERO;
			serial_data_out <= 1'b0;
		end
		else
		begin
			shreg <= next_shreg;
			serial_data_out <= next_serial_data_out;
		end
	end

	// ---------------- checks ----------------
	// [R8] hold while low
	hold_when_low_a: assert property (@(posedge clk) disable iff (!nrst) // [R8]
		(ce && phase == PH_RUN && !le_s) |=> $stable(atten_code))
		else $error("state moved while latch low");

	// [R7] parallel follow
	parallel_follow_a: assert property (@(posedge clk) disable iff (!nrst) // [R7]
		(ce && phase == PH_RUN && le_s && !ps_s) |=> atten_code == $past(pbits_s))
		else $error("parallel word not loaded");

	// [R4] serial load
	serial_load_a: assert property (@(posedge clk) disable iff (!nrst) // [R4]
		(ce && phase == PH_RUN && le_s && ps_s) |=> atten_code == $past(word_s))
		else $error("serial word not loaded");

	// [R11] pin start state
	pup_table_a: assert property (@(posedge clk) disable iff (!nrst) // [R11]
		(ce && phase == PH_BOOT && boot_cnt == CW'(POWERUP_CYCLES - 1) && !le_s)
		|=> atten_code == pup_code($past(pa_s), $past(pb_s)) && powerup_done)
		else $error("wrong select pin start state");

	// [R12] parallel start state
	pup_parallel_a: assert property (@(posedge clk) disable iff (!nrst) // [R12]
		(ce && phase == PH_BOOT && boot_cnt == CW'(POWERUP_CYCLES - 1) && le_s)
		|=> atten_code == $past(pbits_s) && powerup_done)
		else $error("wrong parallel start state");

	// [R13] capture time
	powerup_time_a: assert property (@(posedge clk) disable iff (!nrst) // [R13]
		$rose(powerup_done) |-> $past(boot_cnt) == CW'(POWERUP_CYCLES - 1) && phase == PH_RUN)
		else $error("power-up captured at wrong time");

	// [R17] boot holds default
	boot_hold_a: assert property (@(posedge clk) disable iff (!nrst) // [R17]
		(phase == PH_BOOT) |-> atten_code == `ATTN_CODE_ZERO && !powerup_done)
		else $error("state changed before power-up capture");

	// [R5] shift masked
	shift_mask_a: assert property (@(posedge serial_clk) disable iff (!nrst) // [R5]
		!allow_s |=> $stable(shreg) && $stable(serial_data_out))
		else $error("shift register moved while masked");

	// [R15] cascade delay
	serial_out_delay_a: assert property (@(posedge serial_clk) disable iff (!nrst) // [R15]
		allow_s [*7] |=> serial_data_out == $past(serial_data_in, 7))
		else $error("cascade output not delayed by six");

	// [R16] bit order
	bit_order_a: assert property (@(posedge serial_clk) disable iff (!nrst) // [R16]
		allow_s [*6] |=> shreg[5] == $past(serial_data_in, 6))
		else $error("first serial bit not in bit5");

	// [R5] latch closes the link
	link_mask_a: assert property (@(posedge clk) disable iff (!nrst) // [R5]
		(ce && le_s) |=> !link_allow)
		else $error("link open while latch high");

	// [R6] parallel mode closes the link
	link_mode_a: assert property (@(posedge clk) disable iff (!nrst) // [R6]
		(ce && !ps_s) |=> !link_allow)
		else $error("link open in parallel mode");

	// [R1] serial mode opens the link
	link_open_a: assert property (@(posedge clk) disable iff (!nrst) // [R1]
		(ce && ps_s && !le_s) |=> link_allow)
		else $error("link closed in serial mode");

	// [R13] boot counter steps by one
	boot_count_a: assert property (@(posedge clk) disable iff (!nrst) // [R13]
		(ce && phase == PH_BOOT && boot_cnt != CW'(POWERUP_CYCLES - 1)) |=> boot_cnt == $past(boot_cnt) + CW'(1))
		else $error("boot counter skipped");

	// [R13] run keeps final count
	run_count_a: assert property (@(posedge clk) disable iff (!nrst) // [R13]
		(phase == PH_RUN) |-> boot_cnt == CW'(POWERUP_CYCLES - 1))
		else $error("boot count moved in run");

	// [R17] capture happens once
	done_stays_a: assert property (@(posedge clk) disable iff (!nrst) // [R17]
		powerup_done |=> powerup_done)
		else $error("power-up flag dropped");

	// [R17] run phase is kept
	run_stays_a: assert property (@(posedge clk) disable iff (!nrst) // [R17]
		(phase == PH_RUN) |=> phase == PH_RUN)
		else $error("left run phase without reset");

	// [R8] clock enable freezes state
	ce_freeze_a: assert property (@(posedge clk) disable iff (!nrst) // [R8]
		!ce |=> $stable(boot_cnt) && $stable(atten_code) && $stable(powerup_done))
		else $error("state moved with clock enable low");

	// [R15] cascade takes the top bit
	cascade_bit_a: assert property (@(posedge serial_clk) disable iff (!nrst) // [R15]
		allow_s |=> serial_data_out == $past(shreg[5]))
		else $error("cascade output not from top bit");

	// main scenarios
	cover_serial_load: cover property (@(posedge clk) disable iff (!nrst)
		phase == PH_RUN && ps_s && $rose(le_s));
	cover_parallel_load: cover property (@(posedge clk) disable iff (!nrst)
		phase == PH_RUN && !ps_s && $rose(le_s));
	cover_pup_pins: cover property (@(posedge clk) disable iff (!nrst)
		$rose(powerup_done) && !le_s);
	cover_full_word: cover property (@(posedge serial_clk) disable iff (!nrst)
		allow_s [*6]);
	cover_masked_edge: cover property (@(posedge serial_clk) disable iff (!nrst)
		!allow_s);

endmodule
`default_nettype wire

// File: hdl/attn_cfg.svh
// Function
// [R1] serial input path works only while serial_parallel_select is high
// [R2] controller shifts a full six-bit word, most significant bit first
// [R3] serial data is sampled on each rising serial clock edge
// [R4] serial mode with latch_enable high copies shift register into attenuation state
// [R5] serial clock edges are ignored while latch_enable is high
// [R6] parallel mode disables the serial path and loads from parallel_ctrl_bits
// [R7] parallel mode with latch_enable high sets state from parallel_ctrl_bits
// [R8] attenuation state holds while latch_enable is low, in every mode
// [R9] direct parallel use keeps latch_enable high all the time
// [R10] latched parallel use sets bits with latch_enable low, then pulses it
// [R11] latch_enable low at power-up picks state from the two select pins
// [R12] latch_enable high at power-up takes state from parallel_ctrl_bits
// [R13] power-up state is captured about 200 ms after power is applied
// [R14] control bits are active low, weights 0.25 to 8 dB, summed
// [R15] serial_data_out repeats serial input delayed by six serial clocks
// [R16] first serial bit lands in bit5, last in bit0
// [R17] captured power-up state holds until the first latch update
`ifndef ATTN_CFG_SVH
`define ATTN_CFG_SVH
`define ATTN_WIDTH 6
`define ATTN_CODE_ZERO 6'h3F
`define ATTN_CODE_PUP_00 6'h00
`define ATTN_CODE_PUP_A 6'h0F
`define ATTN_CODE_PUP_B 6'h1F
`define ATTN_CODE_PUP_AB 6'h3F
`define ATTN_POWERUP_MS 200
`define ATTN_CLK_KHZ 20000
`define ATTN_POWERUP_CYCLES (`ATTN_POWERUP_MS * `ATTN_CLK_KHZ)
`define ATTN_SERIAL_DELAY 6
`endif

// File: hdl/attn_pkg.sv
`default_nettype none
package attn_pkg;
	// boot waits out the power-up time, run follows the latch
	typedef enum logic {PH_BOOT, PH_RUN} phase_e;
	typedef logic [5:0] code_t;
endpackage
`default_nettype wire

// File: tb/serial_controller_model.sv
`default_nettype none
module serial_controller_model
(
	output logic serial_clk,
	output logic serial_data_in,
	input wire logic serial_data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock parks low between frames
	initial
	begin
		serial_clk = 1'b0;
		serial_data_in = 1'b0;
	end
	// msb first, cascade output sampled after every edge
	task automatic send(input logic [14:0] v, output logic [5:0] tail);
		tail = 6'h00;
		for (int i = 14; i >= 0; i--)
		begin
			serial_data_in = v[i];
			#7.5 serial_clk = 1'b1;
			#7.5 serial_clk = 1'b0;
			tail = {tail[4:0], serial_data_out};
		end
		serial_data_in = ~v[0]; // released line shows no stale bit
	endtask
endmodule
`default_nettype wire

// File: tb/step_attenuator_control_bench.sv
`default_nettype none
module step_attenuator_control_bench
	import attn_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic latch_enable = 1'b0;
	logic serial_parallel_select = 1'b0;
	logic [5:0] parallel_ctrl_bits = 6'h2A;
	logic powerup_select_a = 1'b0;
	logic powerup_select_b = 1'b0;
	logic serial_clk;
	logic serial_data_in;
	logic serial_data_out;
	logic powerup_done;
	code_t atten_code;
	code_t tail;
	int error_cnt = 0;
	int n_tests = 0;
	always #25 clk = ~clk;
	step_attenuator_control #(.POWERUP_CYCLES(20)) step_attenuator_control_inst (.clk(clk), .nrst(nrst), .ce(1'b1),
		.serial_clk(serial_clk), .serial_data_in(serial_data_in), .latch_enable(latch_enable),
		.serial_parallel_select(serial_parallel_select), .parallel_ctrl_bits(parallel_ctrl_bits),
		.powerup_select_a(powerup_select_a), .powerup_select_b(powerup_select_b), .atten_code(atten_code),
		.powerup_done(powerup_done), .serial_data_out(serial_data_out));
	serial_controller_model serial_controller_model_inst (.serial_clk(serial_clk),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out));
	task automatic check(input string what, input code_t seen, input code_t exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// reset, then capture of the start state
	task automatic boot(input logic le, input logic a, input logic b, input code_t exp);
		@(posedge clk);
		nrst <= 1'b0;
		latch_enable <= le;
		powerup_select_a <= a;
		powerup_select_b <= b;
		tick(16);
		nrst <= 1'b1;
		tick(10);
		check("early code", atten_code, 6'h3F);
		check("early done", {5'h00, powerup_done}, 6'h00);
		tick(15);
		check("boot code", atten_code, exp);
		check("boot done", {5'h00, powerup_done}, 6'h01);
	endtask
	// word shifted in, then one latch pulse
	task automatic serial_word(input logic [14:0] v, input code_t exp_code, input code_t exp_tail);
		serial_controller_model_inst.send(v, tail);
		check("cascade", tail, exp_tail);
		@(posedge clk);
		latch_enable <= 1'b1;
		tick(5);
		latch_enable <= 1'b0;
		tick(4);
		check("serial code", atten_code, exp_code);
	endtask
	// every start state, every weight alone, then latched and serial use
	initial
	begin
		boot(1'b0, 1'b0, 1'b0, 6'h00);
		boot(1'b0, 1'b0, 1'b1, 6'h1F);
		boot(1'b1, 1'b0, 1'b0, 6'h2A);
		boot(1'b0, 1'b1, 1'b1, 6'h3F);
		boot(1'b0, 1'b1, 1'b0, 6'h0F);
		parallel_ctrl_bits <= 6'h15;
		tick(8);
		check("held boot", atten_code, 6'h0F);
		latch_enable <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			parallel_ctrl_bits <= ~(6'h01 << i);
			tick(5);
			check("direct", atten_code, ~(6'h01 << i));
		end
		latch_enable <= 1'b0;
		tick(2);
		parallel_ctrl_bits <= 6'h21;
		tick(6);
		check("latch low", atten_code, 6'h1F);
		latch_enable <= 1'b1;
		tick(4);
		latch_enable <= 1'b0;
		tick(6);
		check("latched", atten_code, 6'h21);
		serial_controller_model_inst.send(15'h7FFF, tail);
		check("parallel link", tail, 6'h00);
		@(posedge clk);
		serial_parallel_select <= 1'b1;
		tick(4);
		serial_word(15'h0000, 6'h00, 6'h00);
		serial_word({3'b111, 6'h15, 6'h2C}, 6'h2C, 6'h15);
		serial_word(15'h0000, 6'h00, 6'h00);
		latch_enable <= 1'b1;
		tick(5);
		serial_controller_model_inst.send(15'h0FFF, tail);
		tick(4);
		check("masked", atten_code, 6'h00);
		conclude();
	end
	// all scenarios need about 17 us, so this leaves wide margin
	initial
	begin
		#400us;
		error_cnt++;
		conclude();
	end
endmodule
`default_nettype wire
